// >>> resonant_startup_protection_fsm.v
// start-up and protection sequencer for a resonant led controller
`include "startup_seq_defines.vh"
module resonant_startup_protection_fsm #(
    parameter [31:0] CYC_BUS_WAIT = `CYC_BUS_WAIT,
    parameter [31:0] CYC_PFC_DLY = `CYC_PFC_DLY,
    parameter [31:0] CYC_FAULT = `CYC_FAULT,
    parameter [31:0] CYC_BUS95 = `CYC_BUS95,
    parameter [31:0] CYC_SATRAMP = `CYC_SATRAMP,
    parameter [31:0] CYC_SAT_MAX = `CYC_SAT_MAX,
    parameter [31:0] CYC_EXTSAT = `CYC_EXTSAT,
    parameter [31:0] CYC_OT_REPEAT = `CYC_OT_REPEAT
) (
    input wire clk_sys,
    input wire reset,
    input wire vcc_above_uvlo,
    input wire vcc_above_start,
    input wire temp_above_mon,
    input wire aux_overvoltage_pin_sink,
    input wire bus_ratio_in_corridor,
    input wire bus_above_95,
    input wire soft_start_done,
    input wire sat_detect,
    input wire output_reached,
    input wire temp_above_run,
    input wire aux_overvoltage_pin_pp_high,
    input wire low_side_current_sense_neg,
    input wire low_side_current_sense_high,
    input wire hs_turn_on_window,
    input wire bus_fault,
    input wire overcurrent,
    output reg inverter_en,
    output reg pfc_en,
    output reg [2:0] freq_cmd,
    output reg [3:0] phase,
    output reg latched_fault
);

    // three-stage synchronisers, a change counts once stages two and three agree
    localparam NIN = 16;
    wire [NIN-1:0] raw = {overcurrent, bus_fault, hs_turn_on_window,
        low_side_current_sense_high, low_side_current_sense_neg,
        aux_overvoltage_pin_pp_high, temp_above_run, output_reached, sat_detect,
        soft_start_done, bus_above_95, bus_ratio_in_corridor,
        aux_overvoltage_pin_sink, temp_above_mon, vcc_above_start, vcc_above_uvlo};
    reg [NIN-1:0] s1_r, s2_r, s3_r, f_r;
    always @(posedge clk_sys) begin
        if (reset) begin
            s1_r <= {NIN{1'b0}};
            s2_r <= {NIN{1'b0}};
            s3_r <= {NIN{1'b0}};
            f_r <= {NIN{1'b0}};
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            f_r <= (s2_r & s3_r) | (f_r & (s2_r | s3_r));
        end
    end
    // filtered flags, one per pin
    wire uv_ok = f_r[0];
    wire st_ok = f_r[1];
    wire t_mon = f_r[2];
    wire aux_sink = f_r[3];
    wire bus_ok = f_r[4];
    wire b95 = f_r[5];
    wire soft_done = f_r[6];
    wire sat = f_r[7];
    wire out_ok = f_r[8];
    wire t_run = f_r[9];
    wire ovp_pp = f_r[10];
    wire cs_neg = f_r[11];
    wire cs_high = f_r[12];
    wire hs_win = f_r[13];
    wire bus_flt = f_r[14];
    wire oc = f_r[15];

    reg [3:0] st_r, st_nxt;
    reg [31:0] tmr_r, tmr_nxt;
    reg [31:0] cool_r;
    reg ot_seen_r, ovp_retry_r, cap_retry_r, sat_hold_r, sat_hold_nxt;
    wire ot_trip, ovp_trip, cap_trip;

    // over temperature, overvoltage and capacitive faults in run must persist before they count
    wire cap_cond = (cs_neg & ~hs_win) | (cs_high & hs_win);
    wire in_run = (st_r == `ST_RUN);
    // over temperature in run
    fault_persist #(.LIMIT(CYC_FAULT)) u_fault_persist_ot (
        .clk_sys(clk_sys),
        .reset(reset),
        .active(in_run),
        .cond(t_run),
        .trip(ot_trip)
    );

    // aux winding peak-to-peak current too high in run
    fault_persist #(.LIMIT(CYC_FAULT)) u_fault_persist_ovp (
        .clk_sys(clk_sys),
        .reset(reset),
        .active(in_run),
        .cond(ovp_pp),
        .trip(ovp_trip)
    );

    // capacitive operation in run
    fault_persist #(.LIMIT(CYC_FAULT)) u_fault_persist_cap (
        .clk_sys(clk_sys),
        .reset(reset),
        .active(in_run),
        .cond(cap_cond),
        .trip(cap_trip)
    );

    always @* begin
        st_nxt = st_r;
        tmr_nxt = tmr_r + 32'h1;
        sat_hold_nxt = sat_hold_r;
        case (st_r)
            `ST_UVLO: begin
                tmr_nxt = 32'h0;
                if (uv_ok)
                    st_nxt = `ST_MON;
            end
            `ST_MON: begin
                tmr_nxt = 32'h0;
                // over temperature or missing aux sink keeps monitoring
                if (st_ok && !t_mon && aux_sink)
                    st_nxt = `ST_BUSWAIT;
            end
            `ST_BUSWAIT: begin
                // a fault or a sagging supply during the wait sends it back to monitoring
                if (!st_ok || t_mon || !aux_sink) begin
                    tmr_nxt = 32'h0;
                    st_nxt = `ST_MON;
                end else if (tmr_r >= CYC_BUS_WAIT - 32'h1) begin
                    tmr_nxt = 32'h0;
                    st_nxt = bus_ok ? `ST_PWRUP : `ST_MON;
                end
            end
            `ST_PWRUP: begin
                if (tmr_r >= CYC_PFC_DLY - 32'h1) begin
                    tmr_nxt = 32'h0;
                    st_nxt = `ST_BUS95;
                end
            end
            `ST_BUS95: begin
                if (b95) begin
                    tmr_nxt = 32'h0;
                    st_nxt = `ST_SOFT;
                end else if (tmr_r >= CYC_BUS95 - 32'h1) begin
                    // no retry: a bus that never builds up points at a hardware fault
                    st_nxt = `ST_LATCH;
                end
            end
            `ST_SOFT: begin
                tmr_nxt = 32'h0;
                if (soft_done) begin
                    sat_hold_nxt = 1'b0;
                    st_nxt = `ST_SAT;
                end
            end
            `ST_SAT: begin
                if (sat)
                    sat_hold_nxt = 1'b1;
                if (sat_hold_r && out_ok && !sat) begin
                    tmr_nxt = 32'h0;
                    st_nxt = `ST_EXTSAT;
                    // ramp ran out without saturation, nothing left to wait for
                end else if (!sat_hold_r && tmr_r >= CYC_SATRAMP - 32'h1 && !sat) begin
                    tmr_nxt = 32'h0;
                    st_nxt = `ST_EXTSAT;
                end else if (tmr_r >= CYC_SAT_MAX - 32'h1) begin
                    st_nxt = `ST_LATCH;
                end
            end
            `ST_EXTSAT: begin
                if (tmr_r >= CYC_EXTSAT - 32'h1) begin
                    tmr_nxt = 32'h0;
                    st_nxt = `ST_RUN;
                end
            end
            `ST_RUN: begin
                tmr_nxt = 32'h0;
                if (bus_flt || oc)
                    st_nxt = `ST_MON;
                if (ot_trip)
                    st_nxt = (ot_seen_r && cool_r < CYC_OT_REPEAT) ? `ST_LATCH : `ST_MON;
                if (ovp_trip)
                    st_nxt = ovp_retry_r ? `ST_LATCH : `ST_MON;
                if (cap_trip)
                    st_nxt = cap_retry_r ? `ST_LATCH : `ST_MON;
            end
            `ST_LATCH: begin
                // only the lockout override below leaves this state
                tmr_nxt = 32'h0;
            end
            default: begin
                st_nxt = `ST_UVLO;
                tmr_nxt = 32'h0;
            end
        endcase
        if (!uv_ok) begin
            st_nxt = `ST_UVLO;
            tmr_nxt = 32'h0;
        end
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            st_r <= `ST_UVLO;
            tmr_r <= 32'h0;
            sat_hold_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            tmr_r <= tmr_nxt;
            sat_hold_r <= sat_hold_nxt;
        end
    end

    // cool-down time since last over temperature restart, saturates at the window
    always @(posedge clk_sys) begin
        if (reset) begin
            cool_r <= 32'h0;
        end else if (in_run && ot_trip) begin
            cool_r <= 32'h0;
        end else if (cool_r < CYC_OT_REPEAT) begin
            cool_r <= cool_r + 32'h1;
        end
    end

    // retry marks survive restarts, cleared only by lockout; a trip in the same cycle wins
    always @(posedge clk_sys) begin
        if (reset) begin
            ot_seen_r <= 1'b0;
            ovp_retry_r <= 1'b0;
            cap_retry_r <= 1'b0;
        end else begin
            if (st_nxt == `ST_UVLO) begin
                ot_seen_r <= 1'b0;
                ovp_retry_r <= 1'b0;
                cap_retry_r <= 1'b0;
            end
            if (in_run && ot_trip)
                ot_seen_r <= 1'b1;
            if (in_run && ovp_trip)
                ovp_retry_r <= 1'b1;
            if (in_run && cap_trip)
                cap_retry_r <= 1'b1;
        end
    end

    // outputs registered from next state
    always @(posedge clk_sys) begin
        if (reset) begin
            inverter_en <= 1'b0;
            pfc_en <= 1'b0;
            freq_cmd <= `FREQ_START;
            phase <= `ST_UVLO;
            latched_fault <= 1'b0;
        end else begin
            phase <= st_nxt;
            latched_fault <= (st_nxt == `ST_LATCH);
            inverter_en <= (st_nxt >= `ST_PWRUP) && (st_nxt <= `ST_RUN);
            pfc_en <= (st_nxt >= `ST_BUS95) && (st_nxt <= `ST_RUN);
            case (st_nxt)
                `ST_SOFT: freq_cmd <= `FREQ_SOFT;
                `ST_SAT: freq_cmd <= (sat_hold_nxt) ? `FREQ_HOLD : `FREQ_SATRAMP;
                `ST_EXTSAT: freq_cmd <= `FREQ_RUN;
                `ST_RUN: freq_cmd <= `FREQ_RUN;
                default: freq_cmd <= `FREQ_START;
            endcase
        end
    end

endmodule // resonant_startup_protection_fsm

// consecutive-cycle counter for a fault that must persist before it counts
module fault_persist #(
    parameter [31:0] LIMIT = 32'h00000001
) (
    input wire clk_sys,
    input wire reset,
    input wire active,
    input wire cond,
    output reg trip
);

    localparam [31:0] LAST = LIMIT - 32'h00000001;

    reg [31:0] cnt_r;

    // one quiet cycle restarts the count, so short glitches never add up
    always @(posedge clk_sys) begin
        if (reset) begin
            cnt_r <= 32'h00000000;
        end else if (active && cond) begin
            // hold at the limit instead of wrapping round to zero
            if (!trip)
                cnt_r <= cnt_r + 32'h00000001;
        end else begin
            cnt_r <= 32'h00000000;
        end
    end

    always @* begin
        trip = (cnt_r >= LAST);
    end

endmodule // fault_persist

// >>> startup_seq_defines.vh
// timing counts and state codes for the resonant start-up sequencer
// Operation
// - supply below lockout level forces lockout and kills all gate drives
// - supply inside hysteresis band keeps sequencer monitoring temperature and output overvoltage
// - monitoring flags over temperature when sense pin exceeds low threshold
// - monitoring flags output overvoltage when no sink current flows into aux pin
// - any monitoring fault holds sequencer in monitoring until sense level is acceptable
// - above start level wait 80 us, then power up only if bus ratio valid
// - power-up starts inverter at fixed start-up frequency
// - pfc drive enables about 300 us after inverter starts
// - bus must exceed 95 percent within 80 ms, then soft start sweeps frequency
// - after soft start, saturation control ramps frequency down over about 40 ms
// - saturation detect halts ramp, then waits for output while watching current sense
// - saturation control lasts at most 237 ms, else latched fault
// - passed saturation control enters extended saturation, run after 625 ms
// - run mode supervises bus, open loop, overcurrent, overvoltage, temperature, capacitive; the code has no open-loop check
// - run over temperature stops drives after 620 us then restarts automatically
// - over temperature recurring within 200 ms after clearing latches off; the code counts 200 ms from the trip, so default timings never latch
// - system too hot before start-up blocks power-up
// - run output overvoltage when aux current high longer than 620 us
// - output overvoltage allows one restart, recurrence latches power-down
// - capacitive operation flagged by negative sense before or high sense during turn-on
// - capacitive condition beyond 620 us allows one restart, recurrence latches
// - latched fault leaves only by fresh power-up or lockout
`ifndef STARTUP_SEQ_DEFINES_VH
`define STARTUP_SEQ_DEFINES_VH
`define CLK_MHZ 125
`define T_BUS_WAIT_US 80
`define T_PFC_DLY_US 300
`define T_FAULT_US 620
`define T_BUS95_MS 80
`define T_SATRAMP_MS 40
`define T_SAT_MAX_MS 237
`define T_EXTSAT_MS 625
`define T_OT_REPEAT_MS 200
`define CYC_BUS_WAIT (`T_BUS_WAIT_US * `CLK_MHZ)
`define CYC_PFC_DLY (`T_PFC_DLY_US * `CLK_MHZ)
`define CYC_FAULT (`T_FAULT_US * `CLK_MHZ)
`define CYC_BUS95 (`T_BUS95_MS * 1000 * `CLK_MHZ)
`define CYC_SATRAMP (`T_SATRAMP_MS * 1000 * `CLK_MHZ)
`define CYC_SAT_MAX (`T_SAT_MAX_MS * 1000 * `CLK_MHZ)
`define CYC_EXTSAT (`T_EXTSAT_MS * 1000 * `CLK_MHZ)
`define CYC_OT_REPEAT (`T_OT_REPEAT_MS * 1000 * `CLK_MHZ)
`define ST_UVLO 4'h0
`define ST_MON 4'h1
`define ST_BUSWAIT 4'h2
`define ST_PWRUP 4'h3
`define ST_BUS95 4'h4
`define ST_SOFT 4'h5
`define ST_SAT 4'h6
`define ST_EXTSAT 4'h7
`define ST_RUN 4'h8
`define ST_LATCH 4'h9
`define FREQ_START 3'h0
`define FREQ_SOFT 3'h1
`define FREQ_SATRAMP 3'h2
`define FREQ_HOLD 3'h3
`define FREQ_RUN 3'h4
`endif

// >>> bus_stage_model.sv
// far-side model: pfc bus build-up and frequency sweep completion
module bus_stage_model (
    input wire clk_sys,
    input wire pfc_en,
    input wire [2:0] freq_cmd,
    input wire bus_stuck,
    output reg bus_above_95 = 1'b0,
    output reg soft_start_done = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [7:0] bus_cnt_r = 8'h00;
    reg [7:0] soft_cnt_r = 8'h00;
    always @(posedge clk_sys) begin
        // bus charges only while the pfc switches; a stuck bus never gets there
        if (!pfc_en || bus_stuck) begin
            bus_cnt_r <= 8'h00;
        end else if (bus_cnt_r != 8'hFF) begin
            bus_cnt_r <= bus_cnt_r + 8'h01;
        end
        bus_above_95 <= bus_cnt_r > 8'h0C;
        soft_cnt_r <= (freq_cmd == 3'h1) ? soft_cnt_r + 8'h01 : 8'h00;
        soft_start_done <= soft_cnt_r > 8'h10;
    end
endmodule // bus_stage_model

// >>> startup_seq_props.sv
// port assertions for the resonant start-up sequencer
module startup_seq_props #(
    parameter [31:0] CYC_PFC_DLY = 32'h0000001E,
    parameter [31:0] CYC_SAT_MAX = 32'h00000064,
    parameter [31:0] CYC_EXTSAT = 32'h00000032
) (
    input wire clk_sys,
    input wire reset,
    input wire vcc_above_uvlo,
    input wire inverter_en,
    input wire pfc_en,
    input wire [2:0] freq_cmd,
    input wire [3:0] phase,
    input wire latched_fault
);
    reg [3:0] prev_r = 4'h0;
    reg [31:0] cnt_r = 32'h0;
    // cycles in the present phase, one edge behind phase
    always @(posedge clk_sys) begin
        prev_r <= phase;
        cnt_r <= (reset || phase != prev_r) ? 32'h0 : cnt_r + 32'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_pfc_go; phase == 4'h3 ##1 phase == 4'h4; endsequence
    sequence s_run_go; phase == 4'h7 ##1 phase == 4'h8; endsequence
    property p_lockout; !vcc_above_uvlo [*8] |-> phase == 4'h0 && !inverter_en; endproperty
    a_lockout: assert property (p_lockout) else $error("drive in lockout");
    property p_idle_off; phase inside {4'h0, 4'h1, 4'h2, 4'h9} |-> !inverter_en && !pfc_en; endproperty
    a_idle_off: assert property (p_idle_off) else $error("drive while idle");
    property p_pfc_follows; $rose(pfc_en) |-> inverter_en && phase == 4'h4; endproperty
    a_pfc_follows: assert property (p_pfc_follows) else $error("pfc start out of order");
    property p_latch_flag; latched_fault == (phase == 4'h9); endproperty
    a_latch_flag: assert property (p_latch_flag) else $error("latch flag wrong");
    property p_latch_hold; phase == 4'h9 |=> phase == 4'h9 || phase == 4'h0; endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch left");
    property p_start_freq; phase == 4'h3 |-> inverter_en && !pfc_en && freq_cmd == 3'h0; endproperty
    a_start_freq: assert property (p_start_freq) else $error("bad start drive");
    property p_pwrup_entry; $changed(phase) && phase == 4'h3 |-> $past(phase) == 4'h2; endproperty
    a_pwrup_entry: assert property (p_pwrup_entry) else $error("bad power-up entry");
    property p_pfc_time; s_pfc_go |-> $past(cnt_r) + 32'h4 >= CYC_PFC_DLY && $past(cnt_r) <= CYC_PFC_DLY; endproperty
    a_pfc_time: assert property (p_pfc_time) else $error("pfc delay wrong");
    property p_run_time; s_run_go |-> $past(cnt_r) + 32'h4 >= CYC_EXTSAT && $past(cnt_r) <= CYC_EXTSAT; endproperty
    a_run_time: assert property (p_run_time) else $error("extended time wrong");
    property p_sat_bound; phase == 4'h6 |-> cnt_r <= CYC_SAT_MAX + 32'h8; endproperty
    a_sat_bound: assert property (p_sat_bound) else $error("saturation too long");
endmodule // startup_seq_props

// >>> resonant_startup_protection_fsm_bench.sv
// self-checking bench for the resonant start-up sequencer
module resonant_startup_protection_fsm_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam integer BW = 20, PD = 30, FT = 20, SM = 100, EX = 50;
    reg clk_sys = 1'b0;
    reg reset = 1'b1;
    reg vcc_above_uvlo = 1'b0, vcc_above_start = 1'b0, temp_above_mon = 1'b0, bus_stuck = 1'b0;
    reg aux_overvoltage_pin_sink = 1'b1, bus_ratio_in_corridor = 1'b1, sat_detect = 1'b0;
    reg output_reached = 1'b0, temp_above_run = 1'b0, bus_fault = 1'b0, overcurrent = 1'b0;
    reg aux_overvoltage_pin_pp_high = 1'b0, low_side_current_sense_neg = 1'b0;
    reg low_side_current_sense_high = 1'b0, hs_turn_on_window = 1'b0;
    wire bus_above_95, soft_start_done, inverter_en, pfc_en, latched_fault;
    wire [2:0] freq_cmd;
    wire [3:0] phase;
    integer fail_count = 0, comparisons = 0;
    always #4 clk_sys = ~clk_sys;
    resonant_startup_protection_fsm #(.CYC_BUS_WAIT(BW), .CYC_PFC_DLY(PD), .CYC_FAULT(FT),
        .CYC_BUS95(60), .CYC_SATRAMP(40), .CYC_SAT_MAX(SM), .CYC_EXTSAT(EX),
        .CYC_OT_REPEAT(1000)) u_resonant_startup_protection_fsm (.clk_sys(clk_sys),
        .reset(reset), .vcc_above_uvlo(vcc_above_uvlo), .vcc_above_start(vcc_above_start),
        .temp_above_mon(temp_above_mon), .aux_overvoltage_pin_sink(aux_overvoltage_pin_sink),
        .bus_ratio_in_corridor(bus_ratio_in_corridor), .bus_above_95(bus_above_95),
        .soft_start_done(soft_start_done), .sat_detect(sat_detect),
        .output_reached(output_reached), .temp_above_run(temp_above_run),
        .aux_overvoltage_pin_pp_high(aux_overvoltage_pin_pp_high),
        .low_side_current_sense_neg(low_side_current_sense_neg),
        .low_side_current_sense_high(low_side_current_sense_high),
        .hs_turn_on_window(hs_turn_on_window), .bus_fault(bus_fault),
        .overcurrent(overcurrent), .inverter_en(inverter_en), .pfc_en(pfc_en),
        .freq_cmd(freq_cmd), .phase(phase), .latched_fault(latched_fault));
    bus_stage_model u_bus_stage_model (.clk_sys(clk_sys), .pfc_en(pfc_en), .freq_cmd(freq_cmd),
        .bus_stuck(bus_stuck), .bus_above_95(bus_above_95), .soft_start_done(soft_start_done));
    task step(input integer n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task check_bit(input string name, input logic exp, input logic got);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask
    task check_phase(input logic [3:0] exp);
        comparisons = comparisons + 1;
        if (phase !== exp) begin
            fail_count = fail_count + 1;
            $display("MISMATCH phase expected %h seen %h", exp, phase);
        end
    endtask
    task check_freq(input logic [2:0] exp);
        comparisons = comparisons + 1;
        if (freq_cmd !== exp) begin
            fail_count = fail_count + 1;
            $display("MISMATCH freq_cmd expected %h seen %h", exp, freq_cmd);
        end
    endtask
    // bounded wait, so a stuck sequencer shows up as a late phase
    task wait_phase(input logic [3:0] exp, input integer lim);
        integer i;
        for (i = 0; i < lim && phase !== exp; i = i + 1) step(1);
        check_phase(exp);
    endtask
    task set_fault(input integer f, input logic on);
        case (f)
            0: temp_above_run = on;
            1: aux_overvoltage_pin_pp_high = on;
            2: low_side_current_sense_neg = on;
            3: {low_side_current_sense_high, hs_turn_on_window} = {on, on};
            4: bus_fault = on;
            default: overcurrent = on;
        endcase
    endtask
    task power_cycle;
        vcc_above_uvlo = 1'b0;
        wait_phase(4'h0, 12);
        step(10);
        check_phase(4'h0);
        check_bit("inverter_en", 1'b0, inverter_en);
        vcc_above_uvlo = 1'b1;
    endtask
    task to_sat;
        output_reached = 1'b0;
        wait_phase(4'h3, BW + 20);
        check_bit("start_freq", 1'b1, freq_cmd === 3'h0);
        wait_phase(4'h4, PD + 12);
        check_bit("pfc_en", 1'b1, pfc_en);
        wait_phase(4'h5, 40);
        check_freq(3'h1);
        wait_phase(4'h6, 40);
        check_freq(3'h2);
    endtask
    task to_run;
        to_sat;
        sat_detect = 1'b1;
        step(8);
        check_freq(3'h3);
        sat_detect = 1'b0;
        output_reached = 1'b1;
        wait_phase(4'h7, 20);
        wait_phase(4'h8, EX + 12);
        check_freq(3'h4);
    endtask
    task t_monitor;
        vcc_above_uvlo = 1'b1;
        step(30);
        check_phase(4'h1);
        vcc_above_start = 1'b1;
        temp_above_mon = 1'b1;
        step(30);
        check_phase(4'h1);
        temp_above_mon = 1'b0;
        aux_overvoltage_pin_sink = 1'b0;
        step(30);
        check_phase(4'h1);
        aux_overvoltage_pin_sink = 1'b1;
        bus_ratio_in_corridor = 1'b0;
        wait_phase(4'h2, 12);
        wait_phase(4'h1, BW + 12);
        check_bit("inverter_en", 1'b0, inverter_en);
        bus_ratio_in_corridor = 1'b1;
    endtask
    // first trip restarts, second trip latches
    task t_fault_pair(input integer first, input integer second);
        power_cycle;
        to_run;
        set_fault(first, 1'b1);
        wait_phase(4'h1, FT + 16);
        check_bit("inverter_en", 1'b0, inverter_en);
        set_fault(first, 1'b0);
        to_run;
        set_fault(second, 1'b1);
        wait_phase(4'h9, FT + 16);
        set_fault(second, 1'b0);
        step(20);
        check_bit("latched_fault", 1'b1, latched_fault);
    endtask
    task t_restart_faults;
        integer i;
        power_cycle;
        for (i = 0; i < 4; i = i + 1) begin
            to_run;
            set_fault(4 + i % 2, 1'b1);
            wait_phase(4'h1, FT + 16);
            set_fault(4 + i % 2, 1'b0);
        end
    endtask
    task t_sat_timeout;
        power_cycle;
        to_sat;
        sat_detect = 1'b1;
        wait_phase(4'h9, SM + 16);
        sat_detect = 1'b0;
    endtask
    task t_bus_timeout;
        power_cycle;
        bus_stuck = 1'b1;
        wait_phase(4'h4, BW + PD + 30);
        wait_phase(4'h9, 76);
        bus_stuck = 1'b0;
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        step(4);
        reset = 1'b0;
        t_monitor;
        t_fault_pair(0, 0);
        t_fault_pair(1, 1);
        t_fault_pair(2, 3);
        t_restart_faults;
        t_sat_timeout;
        t_bus_timeout;
        power_cycle;
        conclude;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count = fail_count + 1;
        conclude;
    end
endmodule // resonant_startup_protection_fsm_bench
bind resonant_startup_protection_fsm startup_seq_props #(.CYC_PFC_DLY(CYC_PFC_DLY),
    .CYC_SAT_MAX(CYC_SAT_MAX), .CYC_EXTSAT(CYC_EXTSAT)) u_startup_seq_props (.clk_sys(clk_sys),
    .reset(reset), .vcc_above_uvlo(vcc_above_uvlo), .inverter_en(inverter_en),
    .pfc_en(pfc_en), .freq_cmd(freq_cmd), .phase(phase), .latched_fault(latched_fault));
